// >>> src/smsr_pkg.sv
// Register map, field positions and frame layout of the synth mode regs
package smsr_pkg;
   localparam int DATA_W = 24;
   localparam int ADDR_W = 6;
   localparam int FRAME_BITS = 1 + ADDR_W + DATA_W;
   localparam int CNT_W = 5;
   localparam logic [5:0] ADDR_MODES = 6'h17;
   localparam logic [5:0] ADDR_BIAS = 6'h18;
   localparam logic [5:0] ADDR_CAL = 6'h19;
   localparam logic [5:0] ADDR_SEED = 6'h1a;
   localparam logic [23:0] RST_MODES = 24'h0001ab;
   localparam logic [23:0] RST_BIAS = 24'h0054c1;
   localparam logic [23:0] RST_CAL = 24'h000aaa;
   localparam logic [23:0] RST_SEED = 24'hb29d0b;
   localparam int MODE_MASTER = 0;
   localparam int MODE_EXT_BUF = 2;
   localparam int MODE_LOOP_BUF = 3;
   localparam int MODE_FIRST_EN = 4;
   localparam int MODE_SECOND_EN = 5;
   localparam int MODE_EXT_IN = 6;
   localparam int MODE_MUTE = 7;
   localparam int MODE_FIRST_SE = 8;
   localparam int MODE_SECOND_SE = 9;
   localparam int MODE_PUMP_SEL = 11;
   localparam int BIAS_LO = 19;
   localparam int BIAS_HI = 20;
   typedef enum logic [1:0] {
      SMSR_IDLE,
      SMSR_SHIFT,
      SMSR_DONE
   } smsr_state_e;
endpackage

// >>> src/smsr_regs.sv
// Synthesizer mode, bias, calibration and seed register bank
`timescale 1ns/1ps
// Overview of operation
// [R01] Modes bit 0, reset 1, is the master enable of the oscillator group.
// [R02] The oscillator group is active only with master enable and chip_en.
// [R03] Modes bit 2, reset 0, enables the external oscillator buffer.
// [R04] Modes bit 3, reset 1, enables the loop buffer for the internal one.
// [R05] Modes bit 4, reset 0, enables the first output buffer pins.
// [R06] Modes bit 5, reset 1, enables the second output buffer pins.
// [R07] Modes bit 6, reset 0, enables the external oscillator input path.
// [R08] Modes bit 7, reset 1, mutes both output buffers until lock.
// [R09] Modes bit 8, reset 1, makes the first output single-ended on neg.
// [R10] Modes bit 9, reset 0, makes the second output single-ended on neg.
// [R11] Modes bit 11 steers the charge pump to output a (0) or b (1).
// [R12] Bias bits 19 and 20 set the external input buffer bias.
// [R13] Software must rewrite the calibration word before use.
// [R14] The 24-bit seed sets the modulator seed and exact-mode phase.
// [R15] Outside exact mode with automatic reseed set, seed sets start phase.
// [R16] Outside exact mode with automatic reseed clear, seed reloads on every frequency change.
// [R17] Every field keeps its written value and reads back until reset.
module smsr_regs (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic chip_en,
   input wire logic cfg_sen_n,
   input wire logic cfg_sck,
   input wire logic cfg_sdi,
   input wire logic pll_locked,
   input wire logic exact_freq_mode,
   input wire logic automatic_reseed,
   input wire logic freq_change,
   output logic cfg_sdo,
   output logic osc_active,
   output logic ext_osc_buf_en,
   output logic loop_buf_en,
   output logic first_out_pos_pin_en,
   output logic first_out_neg_pin_en,
   output logic second_out_pos_pin_en,
   output logic second_out_neg_pin_en,
   output logic ext_input_en,
   output logic pump_output_a_en,
   output logic pump_output_b_en,
   output logic [1:0] ext_input_bias,
   output logic [23:0] calibration_out,
   output logic [23:0] seed_value,
   output logic seed_load
);
   logic [23:0] synth_modes;
   logic [23:0] synth_bias;
   logic [23:0] calibration_word;
   logic [23:0] modulator_seed;
   logic [23:0] next_synth_modes;
   logic [23:0] next_synth_bias;
   logic [23:0] next_calibration_word;
   logic [23:0] next_modulator_seed;

   smsr_pkg::smsr_state_e state;
   smsr_pkg::smsr_state_e next_state;
   logic sck_q;
   logic [smsr_pkg::CNT_W-1:0] bit_cnt;
   logic [smsr_pkg::FRAME_BITS-1:0] shift_in;
   logic [23:0] shift_out;
   logic seed_written;

   function automatic logic [23:0] read_mux(
      input logic [5:0] a,
      input logic [23:0] m,
      input logic [23:0] b,
      input logic [23:0] c,
      input logic [23:0] s
   );
      logic [23:0] r;
      r = 24'h000000;
      if (a == smsr_pkg::ADDR_MODES) begin
         r = m;
      end else if (a == smsr_pkg::ADDR_BIAS) begin
         r = b;
      end else if (a == smsr_pkg::ADDR_CAL) begin
         r = c;
      end else if (a == smsr_pkg::ADDR_SEED) begin
         r = s;
      end
      return r;
   endfunction

   // Serial port edge and frame decode
   wire sck_rise = cfg_sck & ~sck_q;
   wire sck_fall = ~cfg_sck & sck_q;
   wire framed = ~cfg_sen_n;
   wire last_cnt = (bit_cnt == smsr_pkg::CNT_W'(smsr_pkg::FRAME_BITS - 1));
   wire addr_cnt = (bit_cnt == smsr_pkg::CNT_W'(smsr_pkg::ADDR_W));
   wire [smsr_pkg::FRAME_BITS-1:0] frame_next =
      {shift_in[smsr_pkg::FRAME_BITS-2:0], cfg_sdi};
   wire frame_read = shift_in[smsr_pkg::FRAME_BITS-1];
   wire [5:0] frame_addr = shift_in[smsr_pkg::FRAME_BITS-2 -: 6];
   wire [23:0] frame_data = shift_in[23:0];
   wire [5:0] early_addr = frame_next[5:0];
   wire [23:0] early_rdata = read_mux(early_addr, synth_modes, synth_bias,
      calibration_word, modulator_seed);
   wire commit = (state == smsr_pkg::SMSR_DONE) & ~frame_read;
   wire wr_modes = commit & (frame_addr == smsr_pkg::ADDR_MODES);
   wire wr_bias = commit & (frame_addr == smsr_pkg::ADDR_BIAS);
   wire wr_cal = commit & (frame_addr == smsr_pkg::ADDR_CAL);
   wire wr_seed = commit & (frame_addr == smsr_pkg::ADDR_SEED);

   // Frame sequencing
   always_comb begin
      next_state = state;
      unique case (state)
         smsr_pkg::SMSR_IDLE: begin
            if (framed) begin
               next_state = smsr_pkg::SMSR_SHIFT;
            end
         end
         smsr_pkg::SMSR_SHIFT: begin
            if (!framed) begin
               next_state = smsr_pkg::SMSR_IDLE;
            end else if (sck_rise && last_cnt) begin
               next_state = smsr_pkg::SMSR_DONE;
            end
         end
         smsr_pkg::SMSR_DONE: begin
            next_state = smsr_pkg::SMSR_IDLE;
         end
      endcase
   end

   // [R17] Whole-field write, no masking
   assign next_synth_modes = wr_modes ? frame_data : synth_modes;
   assign next_synth_bias = wr_bias ? frame_data : synth_bias;
   // [R13] Calibration word rewritable
   assign next_calibration_word = wr_cal ? frame_data : calibration_word;
   assign next_modulator_seed = wr_seed ? frame_data : modulator_seed;

   // Control derivation
   // [R01] [R02] Master enable with chip enable
   wire active = synth_modes[smsr_pkg::MODE_MASTER] & chip_en;
   // [R08] Pre-lock mute
   wire muted = synth_modes[smsr_pkg::MODE_MUTE] & ~pll_locked;
   wire out_ok = active & ~muted;
   // [R05] [R09] First output pins
   wire first_on = out_ok & synth_modes[smsr_pkg::MODE_FIRST_EN];
   wire first_pos = first_on & ~synth_modes[smsr_pkg::MODE_FIRST_SE];
   // [R06] [R10] Second output pins
   wire second_on = out_ok & synth_modes[smsr_pkg::MODE_SECOND_EN];
   wire second_pos = second_on & ~synth_modes[smsr_pkg::MODE_SECOND_SE];
   // [R11] Pump steering
   wire pump_b = synth_modes[smsr_pkg::MODE_PUMP_SEL];
   // [R14] [R15] [R16] Seed load moments
   wire reload = exact_freq_mode ? seed_written :
      (automatic_reseed ? seed_written : freq_change);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= smsr_pkg::SMSR_IDLE;
         sck_q <= 1'b0;
         bit_cnt <= '0;
         shift_in <= '0;
         shift_out <= 24'h000000;
         cfg_sdo <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         sck_q <= cfg_sck;
         if (!framed) begin
            bit_cnt <= '0;
         end else if (sck_rise && state == smsr_pkg::SMSR_SHIFT) begin
            bit_cnt <= bit_cnt + 1'b1;
            shift_in <= frame_next;
         end
         // Read data loaded once address is complete
         if (framed && sck_rise && addr_cnt && shift_in[5]) begin
            shift_out <= early_rdata;
         end else if (framed && sck_fall &&
                      bit_cnt > smsr_pkg::CNT_W'(smsr_pkg::ADDR_W + 1)) begin
            shift_out <= {shift_out[22:0], 1'b0};
         end
         cfg_sdo <= framed ? shift_out[23] : 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         synth_modes <= smsr_pkg::RST_MODES;
         synth_bias <= smsr_pkg::RST_BIAS;
         calibration_word <= smsr_pkg::RST_CAL;
         modulator_seed <= smsr_pkg::RST_SEED;
         seed_written <= 1'b0;
      end else if (ce) begin
         synth_modes <= next_synth_modes;
         synth_bias <= next_synth_bias;
         calibration_word <= next_calibration_word;
         modulator_seed <= next_modulator_seed;
         seed_written <= wr_seed;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_active <= 1'b0;
         ext_osc_buf_en <= 1'b0;
         loop_buf_en <= 1'b0;
         first_out_pos_pin_en <= 1'b0;
         first_out_neg_pin_en <= 1'b0;
         second_out_pos_pin_en <= 1'b0;
         second_out_neg_pin_en <= 1'b0;
         ext_input_en <= 1'b0;
         pump_output_a_en <= 1'b0;
         pump_output_b_en <= 1'b0;
         ext_input_bias <= 2'h0;
         calibration_out <= smsr_pkg::RST_CAL;
         seed_value <= smsr_pkg::RST_SEED;
         seed_load <= 1'b0;
      end else if (ce) begin
         osc_active <= active;
         // [R03] External oscillator buffer
         ext_osc_buf_en <= active & synth_modes[smsr_pkg::MODE_EXT_BUF];
         // [R04] Loop buffer
         loop_buf_en <= active & synth_modes[smsr_pkg::MODE_LOOP_BUF];
         first_out_pos_pin_en <= first_pos;
         first_out_neg_pin_en <= first_on;
         second_out_pos_pin_en <= second_pos;
         second_out_neg_pin_en <= second_on;
         // [R07] External input path
         ext_input_en <= active & synth_modes[smsr_pkg::MODE_EXT_IN];
         pump_output_a_en <= active & ~pump_b;
         pump_output_b_en <= active & pump_b;
         // [R12] Bias bits
         ext_input_bias <= synth_bias[smsr_pkg::BIAS_HI:smsr_pkg::BIAS_LO];
         calibration_out <= calibration_word;
         // [R14] Seed to modulator
         seed_value <= modulator_seed;
         seed_load <= reload;
      end
   end
endmodule

// >>> tb/smsr_regs_assertions.sv
// Bound checker for the synth mode register bank ports
`timescale 1ns/1ps
module smsr_regs_check (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic chip_en,
   input wire logic cfg_sen_n,
   input wire logic exact_freq_mode,
   input wire logic automatic_reseed,
   input wire logic freq_change,
   input wire logic cfg_sdo,
   input wire logic osc_active,
   input wire logic loop_buf_en,
   input wire logic first_out_pos_pin_en,
   input wire logic first_out_neg_pin_en,
   input wire logic second_out_pos_pin_en,
   input wire logic second_out_neg_pin_en,
   input wire logic pump_output_a_en,
   input wire logic pump_output_b_en,
   input wire logic [23:0] calibration_out,
   input wire logic [23:0] seed_value,
   input wire logic seed_load
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   pump_excl_a: assert property (
      !(pump_output_a_en && pump_output_b_en))
      else $error("pump outputs both on");
   first_se_a: assert property (
      first_out_pos_pin_en |-> first_out_neg_pin_en)
      else $error("first pos without neg");
   second_se_a: assert property (
      second_out_pos_pin_en |-> second_out_neg_pin_en)
      else $error("second pos without neg");
   chip_gate_a: assert property ($past(ce) && $past(ce, 2) && !$past(chip_en)
      && !$past(chip_en, 2) |-> !(osc_active || loop_buf_en
      || first_out_neg_pin_en || pump_output_a_en || pump_output_b_en))
      else $error("enable on without chip enable");
   sdo_idle_a: assert property ($past(cfg_sen_n) && $past(ce) |-> !cfg_sdo)
      else $error("sdo driven outside frame");
   seed_pulse_a: assert property (seed_load |=> !seed_load)
      else $error("seed load longer than one cycle");
   reseed_load_a: assert property (freq_change && ce && !automatic_reseed
      && !exact_freq_mode |-> ##[1:2] seed_load)
      else $error("no seed load after frequency change");
   values_hold_a: assert property ($past(cfg_sen_n) && $past(cfg_sen_n, 2)
      && $past(cfg_sen_n, 3) && $past(cfg_sen_n, 4)
      |-> $stable(seed_value) && $stable(calibration_out))
      else $error("register output moved without a frame");
endmodule
bind smsr_regs smsr_regs_check chk_i (.*);

// >>> tb/testbench.sv
// Self-checking bench for the synth mode register bank
`timescale 1ns/1ps
module testbench;
   logic clk = 0, reset_n = 0, chip_en = 1, sen_n = 1, sck = 0, sdi = 0;
   logic lock = 0, exact = 0, reseed = 1, fchg = 0, ce = 1;
   logic sdo, osc, ext, loopb, fp, fn, sp, sn, ein, pa, pb, sload;
   logic [1:0] bias;
   logic [23:0] cal, seed, q;
   int fail_count = 0, compares = 0, cyc = 0, loads = 0;
   smsr_regs uut (.clk(clk), .reset_n(reset_n), .ce(ce), .chip_en(chip_en),
      .cfg_sen_n(sen_n), .cfg_sck(sck), .cfg_sdi(sdi), .pll_locked(lock),
      .exact_freq_mode(exact), .automatic_reseed(reseed),
      .freq_change(fchg), .cfg_sdo(sdo), .osc_active(osc),
      .ext_osc_buf_en(ext), .loop_buf_en(loopb),
      .first_out_pos_pin_en(fp), .first_out_neg_pin_en(fn),
      .second_out_pos_pin_en(sp), .second_out_neg_pin_en(sn),
      .ext_input_en(ein), .pump_output_a_en(pa), .pump_output_b_en(pb),
      .ext_input_bias(bias), .calibration_out(cal), .seed_value(seed),
      .seed_load(sload));
   wire [23:0] ens = {14'h0, osc, ext, loopb, fp, fn, sp, sn, ein, pa, pb};
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (sload === 1'b1) loads <= loads + 1;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   task give_verdict();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string n, input logic [23:0] e, input logic [23:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // One 31-bit frame, MSB first; read data sampled before each data rise
   task xfer(input logic rw, input logic [5:0] a, input logic [23:0] d);
      logic [30:0] f;
      f = {rw, a, d};
      q = 24'h0;
      sen_n = 0;
      @(negedge clk);
      for (int i = 30; i >= 0; i--) begin
         sdi = f[i];
         if (i < 24) q = {q[22:0], sdo};
         sck = 1;
         repeat (2) @(negedge clk);
         sck = 0;
         repeat (2) @(negedge clk);
      end
      sen_n = 1;
      repeat (4) @(negedge clk);
   endtask
   task rd(input logic [5:0] a, input logic [23:0] e);
      xfer(1'b1, a, 24'h0);
      chk("readback", e, q);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      reset_n = 1;
      @(negedge clk);
      chk("reset enables", 24'h282, ens);
      chk("reset outs", 24'h000aaa, cal ^ {22'h0, bias});
      chk("reset seed", smsr_pkg::RST_SEED, seed);
      rd(smsr_pkg::ADDR_MODES, smsr_pkg::RST_MODES);
      rd(smsr_pkg::ADDR_BIAS, smsr_pkg::RST_BIAS);
      rd(smsr_pkg::ADDR_CAL, smsr_pkg::RST_CAL);
      rd(6'h00, 24'h0);
      $display("test defaults done");
      xfer(1'b0, smsr_pkg::ADDR_MODES, 24'h000a7d);
      chk("all on", 24'h3ed, ens);
      chip_en = 0;
      repeat (3) @(negedge clk);
      chk("chip off", 24'h0, ens);
      chip_en = 1;
      xfer(1'b0, smsr_pkg::ADDR_MODES, 24'h000191);
      chk("muted", 24'h202, ens);
      lock = 1;
      repeat (3) @(negedge clk);
      chk("locked", 24'h222, ens);
      ce = 0;
      chip_en = 0;
      repeat (3) @(negedge clk);
      chk("frozen", 24'h222, ens);
      ce = 1;
      chip_en = 1;
      repeat (3) @(negedge clk);
      rd(smsr_pkg::ADDR_MODES, 24'h000191);
      $display("test modes done");
      xfer(1'b0, smsr_pkg::ADDR_BIAS, 24'h1854c1);
      chk("bias", 24'h3, {22'h0, bias});
      xfer(1'b0, smsr_pkg::ADDR_CAL, 24'h000ab2);
      chk("cal", 24'h000ab2, cal);
      xfer(1'b0, 6'h3f, 24'hffffff);
      rd(6'h3f, 24'h0);
      rd(smsr_pkg::ADDR_CAL, 24'h000ab2);
      xfer(1'b0, smsr_pkg::ADDR_SEED, 24'h123456);
      chk("seed", 24'h123456, seed);
      chk("seed loads", 24'h1, loads[23:0]);
      reseed = 0;
      fchg = 1;
      @(negedge clk);
      fchg = 0;
      repeat (3) @(negedge clk);
      chk("reload", 24'h2, loads[23:0]);
      exact = 1;
      fchg = 1;
      @(negedge clk);
      fchg = 0;
      repeat (3) @(negedge clk);
      chk("exact no reload", 24'h2, loads[23:0]);
      xfer(1'b0, smsr_pkg::ADDR_SEED, 24'habcdef);
      chk("exact seed", 24'habcdef, seed);
      chk("exact load", 24'h3, loads[23:0]);
      $display("test fields done");
      give_verdict();
   end
endmodule
